// >>> logic/rail_bank_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the rail bank.
// Assumes: 25 MHz core clock.
// Notes: Byte offsets are serial-bus register pointers.
`ifndef RAIL_BANK_CONSTS_SVH
`define RAIL_BANK_CONSTS_SVH
`define CLK_MHZ 25
`define BANK_BASE 8'h1a
`define BANK_LAST 8'h29
`define SOFTSTART_SEL_OFS 8'h1a
`define RAIL1_CFG_OFS 8'h1b
`define RAIL1_VCODE_OFS 8'h1c
`define RAIL2_CFG_OFS 8'h1d
`define RAIL2_VCODE_OFS 8'h1e
`define RAIL3_CFG_OFS 8'h1f
`define RAIL3_VCODE_OFS 8'h20
`define RAIL3_SLEEP_VCODE_OFS 8'h21
`define RAIL4_CFG_OFS 8'h22
`define RAIL4_VCODE_OFS 8'h23
`define LIN1_VCODE_OFS 8'h24
`define LIN2_VCODE_OFS 8'h25
`define RAIL_ENABLE_OFS 8'h26
`define LIGHT_SLEEP_OFS 8'h27
`define DEEP_SLEEP_OFS 8'h28
`define FORCED_PWM_OFS 8'h29
`define SW_CFG_RESET 8'h6a
`define SLEEP_RESET 8'h3c
`define LIN2_VCODE_RESET 8'h40
`define SW_CFG_MASK 8'hfe
`define VCODE6_MASK 8'hfc
`define VCODE7_MASK 8'hfe
`define SOFTSTART_MASK 8'h40
`define SLEEP_MASK 8'hfd
`define FPWM_MASK 8'hf0
`define SLEEP_REQ_BIT 0
`define SOFTSTART_BIT 6
`define RAIL1_VSAT 6'h3c
`define RAIL24_VSAT 7'h6e
`define RAIL3_VSAT 7'h50
`define LIN_VSAT 6'h22
`define SLOT_STEP_US 250
`define SST_SHORT_US 250
`define SST_LONG_US 500
`define SLOW_SLEW_MV_US 5'd5
`define I2C_DEV_ADDR 7'h2a
`endif

// >>> logic/rail_bank_pkg.sv
// Purpose: Types shared by the rail configuration bank.
// Assumes: Nothing beyond the constants header.
// Notes: Rails are indexed 5..0 as switcher 1..4 then linear 1..2.
package rail_bank_pkg;
   // Decoded settings of one switching rail.
   typedef struct packed {
      logic [2:0] ilim_amps;
      logic [4:0] slew_up_mv_us;
      logic [4:0] slew_down_mv_us;
      logic [2:0] freq_sel;
      logic forced_pwm;
   } sw_cfg_t;
   typedef sw_cfg_t [3:0] sw_cfg_arr_t;
   // Saturated voltage codes.
   typedef struct packed {
      logic [5:0] rail1;
      logic [6:0] rail2;
      logic [6:0] rail3;
      logic [6:0] rail4;
      logic [5:0] lin1;
      logic [5:0] lin2;
   } vcodes_t;
   typedef logic [5:0][4:0] slot_codes_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
      ST_WDATA, ST_ACK_W, ST_RDATA, ST_ACK_R
   } i2c_state_t;
endpackage

// >>> logic/regulator_rail_config_bank.sv
// Purpose: Rail configuration register bank with serial-bus slave and rail enable control.
// Assumes: Host on a standard two-wire serial bus; sequencer supplies slot run and codes.
// Notes: Bus pins and reset output are asynchronous and pass two flip-flops.
`timescale 1ns/10ps
`include "rail_bank_consts.svh"
module regulator_rail_config_bank #(
   parameter int SLOT_CYCLES = `SLOT_STEP_US * `CLK_MHZ
) (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_SCL,
   input wire logic I_SDA,
   output logic O_SDA_OUT,
   output logic O_SDA_OE,
   input wire logic I_POWER_GOOD_RESET_OUTPUT,
   input wire logic I_SEQ_RUN,
   input wire rail_bank_pkg::slot_codes_t I_SLOT_CODES,
   output rail_bank_pkg::sw_cfg_arr_t O_SW_CFG,
   output rail_bank_pkg::vcodes_t O_VCODES,
   output logic [13:0] O_LIN2_SST_CYCLES,
   output logic [5:0] O_RAIL_ENABLE,
   output logic [5:0] O_RAIL_LOW_POWER,
   output logic O_SLEEP_MODE,
   output logic O_LIGHT_SLEEP_STATE,
   output logic O_DEEP_SLEEP_STATE
);
   import rail_bank_pkg::*;

   localparam logic [13:0] SST_SHORT_CYC = 14'(`SST_SHORT_US * `CLK_MHZ);
   localparam logic [13:0] SST_LONG_CYC = 14'(`SST_LONG_US * `CLK_MHZ);

   logic rst_meta_q, rst_n;
   logic [1:0] scl_q, sda_q;
   logic scl_d1_q, sda_d1_q;
   logic [1:0] pg_q;
   logic [7:0] regs_q [16];
   i2c_state_t st_q;
   logic [7:0] shift_q, ptr_q;
   logic [2:0] cnt_q;
   logic rw_q, wr_stb_q, full_q;
   logic [7:0] rd_byte;
   logic [7:0] wr_data_q, wr_addr_q;
   logic [12:0] slot_tick_q;
   logic [4:0] slot_idx_q;
   logic [5:0] en_bits, en_prev_q, rail_on_q, slot_hit, alive;
   logic scl_rise, scl_fall, start_c, stop_c, sleep_c;

   // Reset release through two flip-flops.
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // Pin synchronisers; stage one feeds stage two only.
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 2'b11;
         sda_q <= 2'b11;
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
         pg_q <= 2'b00;
      end else begin
         scl_q <= {scl_q[0], I_SCL};
         sda_q <= {sda_q[0], I_SDA};
         scl_d1_q <= scl_q[1];
         sda_d1_q <= sda_q[1];
         pg_q <= {pg_q[0], I_POWER_GOOD_RESET_OUTPUT};
      end
   end

   assign scl_rise = scl_q[1] & ~scl_d1_q;
   assign scl_fall = ~scl_q[1] & scl_d1_q;
   assign start_c = scl_q[1] & scl_d1_q & ~sda_q[1] & sda_d1_q;
   assign stop_c = scl_q[1] & scl_d1_q & sda_q[1] & ~sda_d1_q;

   // Read value of a bank offset; reserved bits and unmapped offsets read zero.
   function automatic logic [7:0] rd_val(input logic [7:0] a);
      rd_val = 8'h00;
      if (a >= `BANK_BASE && a <= `BANK_LAST) begin
         rd_val = regs_q[4'(a - `BANK_BASE)];
      end
   endfunction

   // Writable bits of each offset.
   function automatic logic [7:0] wr_mask(input logic [7:0] a);
      unique case (a)
         `SOFTSTART_SEL_OFS: wr_mask = `SOFTSTART_MASK;
         `RAIL1_CFG_OFS, `RAIL2_CFG_OFS, `RAIL3_CFG_OFS,
         `RAIL4_CFG_OFS: wr_mask = `SW_CFG_MASK;
         `RAIL1_VCODE_OFS, `LIN1_VCODE_OFS, `LIN2_VCODE_OFS,
         `RAIL_ENABLE_OFS: wr_mask = `VCODE6_MASK;
         `RAIL2_VCODE_OFS, `RAIL3_VCODE_OFS, `RAIL3_SLEEP_VCODE_OFS,
         `RAIL4_VCODE_OFS: wr_mask = `VCODE7_MASK;
         `LIGHT_SLEEP_OFS, `DEEP_SLEEP_OFS: wr_mask = `SLEEP_MASK;
         `FORCED_PWM_OFS: wr_mask = `FPWM_MASK;
         default: wr_mask = 8'h00;
      endcase
   endfunction

   // Byte that a read would return from the current pointer.
   always_comb begin
      rd_byte = rd_val(ptr_q);
   end

   // Serial slave: address, pointer, write bytes, read bytes with auto-increment.
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         cnt_q <= 3'h0;
         rw_q <= 1'b0;
         O_SDA_OE <= 1'b0;
         wr_stb_q <= 1'b0;
         wr_data_q <= 8'h00;
         wr_addr_q <= 8'h00;
         full_q <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (start_c) begin
            st_q <= ST_ADDR;
            cnt_q <= 3'h0;
            full_q <= 1'b0;
            O_SDA_OE <= 1'b0;
         end else if (stop_c) begin
            st_q <= ST_IDLE;
            O_SDA_OE <= 1'b0;
         end else begin
            unique case (st_q)
               ST_IDLE: begin
               end
               ST_ADDR, ST_PTR, ST_WDATA: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_q[1]};
                     cnt_q <= cnt_q + 3'h1;
                     full_q <= (cnt_q == 3'h7); // The eighth bit is in.
                  end else if (scl_fall && full_q) begin
                     full_q <= 1'b0;
                     unique case (st_q)
                        ST_ADDR: begin
                           if (shift_q[7:1] == `I2C_DEV_ADDR) begin
                              rw_q <= shift_q[0];
                              O_SDA_OE <= 1'b1;
                              st_q <= ST_ACK_ADDR;
                           end else begin
                              st_q <= ST_IDLE;
                           end
                        end
                        ST_PTR: begin
                           ptr_q <= shift_q;
                           O_SDA_OE <= 1'b1;
                           st_q <= ST_ACK_PTR;
                        end
                        default: begin
                           wr_addr_q <= ptr_q;
                           wr_data_q <= shift_q;
                           wr_stb_q <= 1'b1;
                           ptr_q <= ptr_q + 8'h01;
                           O_SDA_OE <= 1'b1;
                           st_q <= ST_ACK_W;
                        end
                     endcase
                  end
               end
               ST_ACK_ADDR: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        shift_q <= rd_byte;
                        O_SDA_OE <= ~rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= ST_RDATA;
                     end else begin
                        O_SDA_OE <= 1'b0;
                        st_q <= ST_PTR;
                     end
                  end
               end
               ST_ACK_PTR, ST_ACK_W: begin
                  if (scl_fall) begin
                     O_SDA_OE <= 1'b0;
                     st_q <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_rise) begin
                     cnt_q <= cnt_q + 3'h1;
                  end else if (scl_fall) begin
                     if (cnt_q == 3'h0) begin
                        O_SDA_OE <= 1'b0;
                        st_q <= ST_ACK_R;
                     end else begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        O_SDA_OE <= ~shift_q[6];
                     end
                  end
               end
               ST_ACK_R: begin
                  if (scl_rise) begin
                     rw_q <= ~sda_q[1];
                  end else if (scl_fall) begin
                     if (rw_q) begin
                        shift_q <= rd_byte;
                        O_SDA_OE <= ~rd_byte[7];
                        ptr_q <= ptr_q + 8'h01;
                        st_q <= ST_RDATA;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   assign O_SDA_OUT = 1'b0;

   // Register storage with documented reset values; only writable bits change.
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            regs_q[i] <= 8'h00;
         end
         regs_q[4'(`RAIL1_CFG_OFS - `BANK_BASE)] <= `SW_CFG_RESET;
         regs_q[4'(`RAIL2_CFG_OFS - `BANK_BASE)] <= `SW_CFG_RESET;
         regs_q[4'(`RAIL3_CFG_OFS - `BANK_BASE)] <= `SW_CFG_RESET;
         regs_q[4'(`RAIL4_CFG_OFS - `BANK_BASE)] <= `SW_CFG_RESET;
         regs_q[4'(`LIN2_VCODE_OFS - `BANK_BASE)] <= `LIN2_VCODE_RESET;
         regs_q[4'(`LIGHT_SLEEP_OFS - `BANK_BASE)] <= `SLEEP_RESET;
         regs_q[4'(`DEEP_SLEEP_OFS - `BANK_BASE)] <= `SLEEP_RESET;
      end else if (wr_stb_q && wr_addr_q >= `BANK_BASE && wr_addr_q <= `BANK_LAST) begin
         regs_q[4'(wr_addr_q - `BANK_BASE)] <= wr_data_q & wr_mask(wr_addr_q);
      end
   end

   // Decode of each switcher's configuration byte.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         logic [7:0] c;
         c = regs_q[4'(`RAIL1_CFG_OFS - `BANK_BASE + 2 * i + (i == 3 ? 1 : 0))];
         if (i == 0 || i == 2) begin
            O_SW_CFG[3 - i].ilim_amps = 3'd4 + {1'b0, c[7:6]};
         end else begin
            O_SW_CFG[3 - i].ilim_amps = 3'd2 + {1'b0, c[7:6]};
         end
         O_SW_CFG[3 - i].slew_up_mv_us = 5'd20 - 5'd5 * {3'b000, c[5:4]};
         O_SW_CFG[3 - i].slew_down_mv_us = `SLOW_SLEW_MV_US;
         O_SW_CFG[3 - i].freq_sel = c[3] ? 3'd1 + {1'b0, c[2:1]} : 3'd0;
         O_SW_CFG[3 - i].forced_pwm = regs_q[4'(`FORCED_PWM_OFS - `BANK_BASE)][7 - i];
      end
   end

   // Saturated voltage codes; rail 3 follows its sleep code while asleep.
   always_comb begin
      logic [7:0] r3;
      r3 = sleep_c ? regs_q[4'(`RAIL3_SLEEP_VCODE_OFS - `BANK_BASE)]
                   : regs_q[4'(`RAIL3_VCODE_OFS - `BANK_BASE)];
      O_VCODES.rail1 = regs_q[4'(`RAIL1_VCODE_OFS - `BANK_BASE)][7:2];
      if (O_VCODES.rail1 > `RAIL1_VSAT) O_VCODES.rail1 = `RAIL1_VSAT;
      O_VCODES.rail2 = regs_q[4'(`RAIL2_VCODE_OFS - `BANK_BASE)][7:1];
      if (O_VCODES.rail2 > `RAIL24_VSAT) O_VCODES.rail2 = `RAIL24_VSAT;
      O_VCODES.rail4 = regs_q[4'(`RAIL4_VCODE_OFS - `BANK_BASE)][7:1];
      if (O_VCODES.rail4 > `RAIL24_VSAT) O_VCODES.rail4 = `RAIL24_VSAT;
      O_VCODES.rail3 = (r3[7:1] > `RAIL3_VSAT) ? `RAIL3_VSAT : r3[7:1];
      O_VCODES.lin1 = regs_q[4'(`LIN1_VCODE_OFS - `BANK_BASE)][7:2];
      if (O_VCODES.lin1 > `LIN_VSAT) O_VCODES.lin1 = `LIN_VSAT;
      O_VCODES.lin2 = regs_q[4'(`LIN2_VCODE_OFS - `BANK_BASE)][7:2];
      if (O_VCODES.lin2 > `LIN_VSAT) O_VCODES.lin2 = `LIN_VSAT;
   end

   // Linear 2 soft-start time in core cycles.
   assign O_LIN2_SST_CYCLES =
      regs_q[4'(`SOFTSTART_SEL_OFS - `BANK_BASE)][`SOFTSTART_BIT] ? SST_LONG_CYC
                                                                 : SST_SHORT_CYC;

   // Sleep decode: either request sleeps; a rail lives only if alive in both.
   assign sleep_c = regs_q[4'(`LIGHT_SLEEP_OFS - `BANK_BASE)][`SLEEP_REQ_BIT]
                  | regs_q[4'(`DEEP_SLEEP_OFS - `BANK_BASE)][`SLEEP_REQ_BIT];
   assign alive = regs_q[4'(`LIGHT_SLEEP_OFS - `BANK_BASE)][7:2]
                & regs_q[4'(`DEEP_SLEEP_OFS - `BANK_BASE)][7:2];
   assign O_SLEEP_MODE = sleep_c;
   assign O_LIGHT_SLEEP_STATE = regs_q[4'(`LIGHT_SLEEP_OFS - `BANK_BASE)][`SLEEP_REQ_BIT];
   assign O_DEEP_SLEEP_STATE = regs_q[4'(`DEEP_SLEEP_OFS - `BANK_BASE)][`SLEEP_REQ_BIT];
   assign O_RAIL_LOW_POWER = sleep_c ? (alive & rail_on_q) : 6'h00;
   assign O_RAIL_ENABLE = sleep_c ? (alive & rail_on_q) : rail_on_q;
   assign en_bits = regs_q[4'(`RAIL_ENABLE_OFS - `BANK_BASE)][7:2];

   // Power-up slot timer: slot index advances every slot step up to 31 while the sequence runs.
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         slot_tick_q <= 13'h0000;
         slot_idx_q <= 5'h00;
      end else if (!I_SEQ_RUN) begin
         slot_tick_q <= 13'h0000;
         slot_idx_q <= 5'h00;
      end else if (slot_tick_q == 13'(SLOT_CYCLES - 1)) begin
         slot_tick_q <= 13'h0000;
         if (slot_idx_q != 5'h1f) slot_idx_q <= slot_idx_q + 5'h01;
      end else begin
         slot_tick_q <= slot_tick_q + 13'h0001;
      end
   end

   // A slot code of zero never fires; code n fires in slot n-1.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         slot_hit[i] = I_SEQ_RUN && I_SLOT_CODES[i] != 5'h00
                    && slot_idx_q >= I_SLOT_CODES[i] - 5'h01;
      end
   end

   // Rail on state from the enable bits, reset output and time slots.
   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rail_on_q <= 6'h00;
         en_prev_q <= 6'h00;
      end else begin
         en_prev_q <= en_bits;
         for (int i = 0; i < 6; i++) begin
            if (!en_bits[i]) begin
               rail_on_q[i] <= 1'b0;
            end else if (pg_q[1] && !en_prev_q[i]) begin
               rail_on_q[i] <= 1'b1;
            end else if (!pg_q[1] && slot_hit[i]) begin
               rail_on_q[i] <= 1'b1;
            end
         end
      end
   end

   // Checks.
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!rst_n);
   sequence en_rise_s(int k);
      en_bits[k] && !en_prev_q[k] && pg_q[1];
   endsequence
   immediate_start_a: assert property (en_rise_s(5) |=> rail_on_q[5])
      else $error("Rail 1 did not start after enable write with reset output high.");
   no_slot_start_a: assert property (!pg_q[1] && !slot_hit[0] && !rail_on_q[0]
      |=> !rail_on_q[0])
      else $error("Linear 2 started outside its time slot.");
   enable_off_a: assert property (!en_bits[2] |=> !rail_on_q[2])
      else $error("Rail 4 stayed on with enable bit clear.");
   sleep_off_wins_a: assert property (sleep_c && !alive[3] |-> !O_RAIL_ENABLE[3])
      else $error("Rail 3 enabled in sleep without both alive bits.");
   normal_mode_a: assert property (!sleep_c |-> O_RAIL_LOW_POWER == 6'h00
      && O_RAIL_ENABLE == rail_on_q)
      else $error("Low-power state seen in normal mode.");
   rail1_sat_a: assert property (O_VCODES.rail1 <= 6'h3c && O_VCODES.rail3 <= 7'h50)
      else $error("Voltage code above saturation.");
   reserved_zero_a: assert property (wr_stb_q && wr_addr_q == `FORCED_PWM_OFS
      |=> regs_q[15] == ($past(wr_data_q) & 8'hf0))
      else $error("Forced-PWM write did not keep reserved bits zero.");
   slew_map_a: assert property (O_SW_CFG[3].slew_down_mv_us == 5'd5
      && (regs_q[1][5:4] != 2'b10 || O_SW_CFG[3].slew_up_mv_us == 5'd10))
      else $error("Slew decode wrong for rail 1.");
   freq_map_a: assert property (regs_q[1][3] == 1'b0 |-> O_SW_CFG[3].freq_sel == 3'd0)
      else $error("Low frequency codes not collapsed.");
   ilim_map_a: assert property ((regs_q[3][7:6] != 2'b01 || O_SW_CFG[2].ilim_amps == 3'd3)
      && (regs_q[3][7:6] != 2'b11 || O_SW_CFG[2].ilim_amps == 3'd5))
      else $error("Rail 2 current limit decode wrong.");
endmodule // regulator_rail_config_bank

// >>> verification/i2c_host_model.sv
// Purpose: Serial two-wire bus master that stands in for the host controller.
// Assumes: Open-drain data with a pull-up; the bench resolves the wire level.
// Notes: Clock phases are whole core cycles, each at least four cycles long.
`timescale 1ns/10ps
`include "rail_bank_consts.svh"
module i2c_host_model (
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   logic ack_q;
   // Both lines are released at time zero, so the bus idles high.
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      ack_q = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // Start or repeated start: data falls while the clock is high.
   task automatic start_cond();
      o_sda_low <= 1'b0;
      tick(4);
      o_scl <= 1'b1;
      tick(8);
      o_sda_low <= 1'b1;
      tick(8);
      o_scl <= 1'b0;
      tick(4);
   endtask
   // Stop: data rises while the clock is high, leaving the bus idle.
   task automatic stop_cond();
      o_sda_low <= 1'b1;
      tick(4);
      o_scl <= 1'b1;
      tick(8);
      o_sda_low <= 1'b0;
      tick(8);
   endtask
   // One clock pulse; data changes only mid-way through the low phase.
   task automatic bit_cycle(input logic drive_low, output logic seen);
      o_sda_low <= drive_low;
      tick(4);
      o_scl <= 1'b1;
      tick(8);
      seen = i_sda;
      o_scl <= 1'b0;
      tick(4);
   endtask
   // Byte out, most significant bit first, then the slave acknowledge.
   task automatic send_byte(input logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(!b[i], s);
      end
      bit_cycle(1'b0, s);
      ack_q = !s;
   endtask
   // Byte in, then a not-acknowledge so the slave ends the read.
   task automatic recv_byte(output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b0, b[i]);
      end
      bit_cycle(1'b0, s);
   endtask
   // One register write; each code goes in as a single final value.
   task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
      start_cond();
      send_byte({`I2C_DEV_ADDR, 1'b0});
      send_byte(ofs);
      send_byte(dat);
      stop_cond();
   endtask
   // One register read through a repeated start.
   task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
      start_cond();
      send_byte({`I2C_DEV_ADDR, 1'b0});
      send_byte(ofs);
      start_cond();
      send_byte({`I2C_DEV_ADDR, 1'b1});
      recv_byte(dat);
      stop_cond();
   endtask
endmodule // i2c_host_model

// >>> verification/regulator_rail_config_bank_tb_top.sv
// Purpose: Self-checking bench for the rail configuration bank.
// Assumes: Slot length shortened to 8 core cycles.
// Notes: All registers are reached over the serial bus only.
`timescale 1ns/10ps
`include "rail_bank_consts.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module regulator_rail_config_bank_tb_top;
   import rail_bank_pkg::*;
   logic I_CLK, I_RESETN, scl, host_sda_low, sda, pg, seq_run, sda_out, sda_oe;
   logic sleep, light, deep;
   slot_codes_t slot_codes;
   sw_cfg_arr_t sw_cfg;
   vcodes_t vcodes;
   logic [13:0] sst;
   logic [5:0] rail_en, low_pw;
   logic [7:0] d;
   logic [1:0] c2;
   int n_errors = 0;
   int n_compared = 0;
   logic [7:0] rst_tab [16] = '{8'h00, 8'h6a, 8'h00, 8'h6a, 8'h00, 8'h6a, 8'h00, 8'h00,
                                8'h6a, 8'h00, 8'h00, 8'h40, 8'h00, 8'h3c, 8'h3c, 8'h00};
   logic [7:0] msk_tab [16] = '{8'h40, 8'hfe, 8'hfc, 8'hfe, 8'hfe, 8'hfe, 8'hfe, 8'hfe,
                                8'hfe, 8'hfe, 8'hfc, 8'hfc, 8'hfc, 8'hfd, 8'hfd, 8'hf0};
   // The pull-up wins unless either party pulls the data line low.
   assign sda = !(host_sda_low | sda_oe);
   always #20 I_CLK = ~I_CLK;
   i2c_host_model i_i2c_host_model (.i_clk(I_CLK), .i_sda(sda), .o_scl(scl),
      .o_sda_low(host_sda_low));
   regulator_rail_config_bank #(.SLOT_CYCLES(8)) i_regulator_rail_config_bank (
      .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
      .O_SDA_OE(sda_oe), .I_POWER_GOOD_RESET_OUTPUT(pg), .I_SEQ_RUN(seq_run),
      .I_SLOT_CODES(slot_codes), .O_SW_CFG(sw_cfg), .O_VCODES(vcodes),
      .O_LIN2_SST_CYCLES(sst), .O_RAIL_ENABLE(rail_en), .O_RAIL_LOW_POWER(low_pw),
      .O_SLEEP_MODE(sleep), .O_LIGHT_SLEEP_STATE(light), .O_DEEP_SLEEP_STATE(deep));
   // Closing verdict, reached from the main sequence or the watchdog.
   task automatic results();
      $display("compared=%0d mismatches=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] dat);
      i_i2c_host_model.wr(ofs, dat);
      `CHK(i_i2c_host_model.ack_q, 1'b1)
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge I_CLK);
      @(negedge I_CLK);
   endtask
   // Watchdog sized at about two and a half times the expected run.
   initial begin
      repeat (90000) @(posedge I_CLK);
      n_errors++;
      results();
   end
   // Main sequence of tests.
   initial begin
      I_CLK = 1'b0;
      I_RESETN = 1'b0;
      pg = 1'b1;
      seq_run = 1'b0;
      slot_codes = '0;
      repeat (3) @(posedge I_CLK);
      I_RESETN <= 1'b1;
      repeat (6) @(posedge I_CLK);
      for (int i = 0; i < 16; i++) begin
         i_i2c_host_model.rd(8'h1a + i[7:0], d);
         `CHK(d, rst_tab[i])
      end
      settle(1);
      `CHK(sw_cfg[3].ilim_amps, 3'd5)
      `CHK(sw_cfg[2].ilim_amps, 3'd3)
      `CHK({sw_cfg[0].slew_up_mv_us, sw_cfg[0].slew_down_mv_us}, {5'd10, 5'd5})
      `CHK(sw_cfg[1].freq_sel, 3'd2)
      `CHK({vcodes.lin2, sst, rail_en, sda_out}, {6'h10, 14'd6250, 6'h00, 1'b0})
      $display("test reset_values done");
      for (int c = 0; c < 8; c++) begin
         c2 = c[1:0];
         wr(`RAIL1_CFG_OFS, {c2, c2, c[2:0], 1'b0});
         settle(1);
         `CHK(sw_cfg[3].ilim_amps, 3'd4 + {1'b0, c2})
         `CHK(sw_cfg[3].slew_up_mv_us, 5'd20 - 5'd5 * {3'd0, c2})
         `CHK(sw_cfg[3].freq_sel, (c < 4) ? 3'd0 : c[2:0] - 3'd3)
      end
      $display("test field_codes done");
      for (int i = 0; i < 16; i++) begin
         wr(8'h1a + i[7:0], 8'hff);
      end
      for (int i = 0; i < 17; i++) begin
         i_i2c_host_model.rd(8'h1a + i[7:0], d);
         `CHK(d, (i < 16) ? msk_tab[i] : 8'h00)
      end
      settle(1);
      `CHK({sw_cfg[3].ilim_amps, sw_cfg[0].ilim_amps}, {3'd7, 3'd5})
      `CHK({sw_cfg[1].slew_up_mv_us, sw_cfg[2].freq_sel}, {5'd5, 3'd4})
      `CHK({sw_cfg[0].forced_pwm, sw_cfg[3].forced_pwm}, 2'b11)
      `CHK({vcodes.rail1, vcodes.rail2, vcodes.rail4}, {6'h3c, 7'h6e, 7'h6e})
      `CHK({vcodes.rail3, vcodes.lin1, vcodes.lin2}, {7'h50, 6'h22, 6'h22})
      `CHK({sst, rail_en, low_pw}, {14'd12500, 6'h3f, 6'h3f})
      $display("test write_masks done");
      wr(`RAIL_ENABLE_OFS, 8'hfc);
      wr(`RAIL3_VCODE_OFS, 8'h20);
      wr(`RAIL3_SLEEP_VCODE_OFS, 8'h0a);
      wr(`DEEP_SLEEP_OFS, 8'h3c);
      wr(`LIGHT_SLEEP_OFS, 8'hf1);
      settle(1);
      `CHK({rail_en, low_pw}, {6'h0c, 6'h0c})
      `CHK({sleep, light, deep, vcodes.rail3}, {3'b110, 7'h05})
      wr(`LIGHT_SLEEP_OFS, 8'hf0);
      wr(`DEEP_SLEEP_OFS, 8'h3d);
      settle(1);
      `CHK({sleep, light, deep, rail_en}, {3'b101, 6'h0c})
      wr(`DEEP_SLEEP_OFS, 8'h3c);
      settle(1);
      `CHK({sleep, rail_en, low_pw, vcodes.rail3}, {1'b0, 6'h3f, 6'h00, 7'h10})
      $display("test sleep_modes done");
      @(posedge I_CLK);
      pg <= 1'b0;
      slot_codes <= {5'd1, 5'd3, 20'd0};
      wr(`RAIL_ENABLE_OFS, 8'h00);
      settle(1);
      `CHK(rail_en, 6'h00)
      wr(`RAIL_ENABLE_OFS, 8'hfc);
      settle(40);
      `CHK(rail_en, 6'h00)
      @(posedge I_CLK);
      seq_run <= 1'b1;
      settle(10);
      `CHK(rail_en, 6'h20)
      settle(20);
      `CHK(rail_en, 6'h30)
      $display("test time_slots done");
      results();
   end
endmodule // regulator_rail_config_bank_tb_top
